// *** src/gpt_map.svh ***
// register offsets, field positions, reset values and timing counts of the timer pair
`ifndef GPT_MAP_SVH
`define GPT_MAP_SVH

`define GPT_OFS_CFG 8'h00
`define GPT_OFS_MODE_A 8'h04
`define GPT_OFS_MODE_B 8'h08
`define GPT_OFS_CTL 8'h0c
`define GPT_OFS_IMR 8'h18
`define GPT_OFS_RIS 8'h1c
`define GPT_OFS_MIS 8'h20
`define GPT_OFS_ICR 8'h24
`define GPT_OFS_ILR_A 8'h28
`define GPT_OFS_ILR_B 8'h2c
`define GPT_OFS_MATCH_A 8'h30
`define GPT_OFS_MATCH_B 8'h34
`define GPT_OFS_PRE_A 8'h38
`define GPT_OFS_PRE_B 8'h3c
`define GPT_OFS_CNT_A 8'h48
`define GPT_OFS_CNT_B 8'h4c

`define GPT_CFG_JOINED 3'h0
`define GPT_CFG_CLOCK 3'h1
`define GPT_CFG_SPLIT 3'h4
`define GPT_MODE_ONESHOT 2'h1
`define GPT_MODE_PERIODIC 2'h2

// control bits, half b enable, stall and trigger sit at half a position plus 8
`define GPT_CTL_EN 0
`define GPT_CTL_STALL 1
`define GPT_CTL_CAL 4
`define GPT_CTL_OTE 5
`define GPT_HALF_STRIDE 8
// status and mask bits
`define GPT_IRQ_TO 0
`define GPT_IRQ_MATCH 3

`define GPT_CNT_RST 16'hffff
`define GPT_PRE_RST 8'h00
`define GPT_CLOCK_FIRST 32'h00000001

`define GPT_REF_HZ 32768
`define GPT_TICK_HZ 1
`define GPT_REF_PER_TICK (`GPT_REF_HZ / `GPT_TICK_HZ)

`endif

// *** src/gpt_pkg.sv ***
// types of the timer pair
`include "gpt_map.svh"
package gpt_pkg;
    typedef struct packed {
        logic [2:0] cfg;
        logic [1:0][1:0] mode;
        logic [15:0] ctl;
        logic [15:0] imr;
        logic [15:0] ris;
        logic [1:0][15:0] ild;
        logic [1:0][15:0] mt;
        logic [1:0][7:0] pre;
        logic [1:0][7:0] psc;
        logic [1:0][15:0] cnt;
        logic [1:0] reload;
        logic [1:0] trig;
        logic clock_seen;
        logic [2:0] sync;
        logic ref_lvl;
        logic [15:0] div;
        logic irq;
        logic [31:0] rdata;
    } gpt_state_t;
endpackage

// *** src/gpt_timer_pair.sv ***
// two 16-bit timer halves, joinable into a 32-bit timer or seconds counter
//
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "gpt_map.svh"
module gpt_timer_pair #(
    parameter int REF_PER_TICK = `GPT_REF_PER_TICK
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic halt,
    input wire logic capture_pin_0,
    output logic irq,
    output logic trig_a,
    output logic trig_b
);
    gpt_pkg::gpt_state_t s;
    gpt_pkg::gpt_state_t n;

    // register map, byte offsets on reg_addr:
    // 00 width config: 0 joined down-counter, 1 seconds counter, 4 two halves
    // 04, 08 half a / half b mode: 1 one-shot, anything else periodic
    // 0c control: bit 0 enable, 1 stall, 4 calendar, 5 trigger; half b enable, stall and trigger at plus 8
    // 18 mask, 1c raw status, 20 masked status, 24 clear (write one to clear)
    // status bits: 0 half a or joined time-out, 3 seconds match, 8 half b time-out
    // 28, 2c interval loads; 30, 34 match values; 38, 3c prescales
    // 48, 4c count values, read only
    // joined and seconds modes: 28, 30 and 48 carry both halves, half b on top
    // a load write re-arms the count on the next edge, except a 2c write outside split mode
    // and any load write in seconds mode, where software moves the count through the match value instead
    // split mode: prescale p steps a half once every p+1 clocks
    // a new prescale takes effect at the next count step or reload of that half
    // a flag set and its clear in one cycle: the set wins, no event is lost
    // a software control write beats a hardware enable clear in the same cycle
    // halt is taken as synchronous to clock; a halt from elsewhere needs a
    // synchroniser in front of this block
    // the seconds divider restarts whenever the enable is cleared

    logic [15:0] set_v;
    logic [15:0] clr_v;
    logic [31:0] c32;
    logic [31:0] m32;
    logic hold;
    logic ref_rise;
    logic en_i;
    logic stall_i;
    logic joined;

    always_comb begin
        n = s;
        set_v = 16'h0000;
        clr_v = 16'h0000;
        c32 = s.cnt;
        m32 = s.mt;
        en_i = 1'b0;
        stall_i = 1'b0;
        ref_rise = 1'b0;
        n.trig = 2'b00;
        joined = (s.cfg != `GPT_CFG_SPLIT);
        hold = halt && !s.ctl[`GPT_CTL_CAL];

        // third and second stage must agree before the level is taken
        n.sync = {s.sync[1:0], capture_pin_0};
        if (s.sync[1] == s.sync[2] && s.sync[2] != s.ref_lvl) begin
            n.ref_lvl = s.sync[2];
            ref_rise = s.sync[2];
        end

        case (s.cfg)
            `GPT_CFG_JOINED: begin
                if (s.reload[0]) begin
                    n.cnt = s.ild;
                    n.reload = 2'b00;
                end else if (s.ctl[`GPT_CTL_EN] && !(hold && s.ctl[`GPT_CTL_STALL])) begin
                    if (c32 == 32'h00000000) begin
                        set_v[`GPT_IRQ_TO] = 1'b1;
                        n.trig[0] = s.ctl[`GPT_CTL_OTE];
                        n.reload[0] = 1'b1;
                        if (s.mode[0] == `GPT_MODE_ONESHOT) begin
                            n.ctl[`GPT_CTL_EN] = 1'b0;
                        end
                    end else begin
                        n.cnt = c32 - 32'h00000001;
                    end
                end
            end
            `GPT_CFG_CLOCK: begin
                if (!s.clock_seen) begin
                    n.clock_seen = 1'b1;
                    n.cnt = `GPT_CLOCK_FIRST;
                end
                n.reload = 2'b00;
                if (!s.ctl[`GPT_CTL_EN]) begin
                    n.div = 16'h0000;
                end else if (ref_rise) begin
                    if (s.div == 16'(REF_PER_TICK - 1)) begin
                        n.div = 16'h0000;
                        if (c32 == m32) begin
                            n.cnt = 32'h00000000;
                            set_v[`GPT_IRQ_MATCH] = 1'b1;
                        end else begin
                            n.cnt = c32 + 32'h00000001;
                        end
                    end else begin
                        n.div = s.div + 16'h0001;
                    end
                end
            end
            `GPT_CFG_SPLIT: begin
                for (int i = 0; i < 2; i++) begin
                    en_i = s.ctl[`GPT_CTL_EN + `GPT_HALF_STRIDE * i];
                    stall_i = s.ctl[`GPT_CTL_STALL + `GPT_HALF_STRIDE * i];
                    if (s.reload[i]) begin
                        n.cnt[i] = s.ild[i];
                        n.psc[i] = s.pre[i];
                        n.reload[i] = 1'b0;
                    end else if (en_i && !(hold && stall_i)) begin
                        if (s.psc[i] != 8'h00) begin
                            n.psc[i] = s.psc[i] - 8'h01;
                        end else if (s.cnt[i] == 16'h0000) begin
                            set_v[`GPT_IRQ_TO + `GPT_HALF_STRIDE * i] = 1'b1;
                            n.trig[i] = s.ctl[`GPT_CTL_OTE + `GPT_HALF_STRIDE * i];
                            n.reload[i] = 1'b1;
                            if (s.mode[i] == `GPT_MODE_ONESHOT) begin
                                n.ctl[`GPT_CTL_EN + `GPT_HALF_STRIDE * i] = 1'b0;
                            end
                        end else begin
                            n.cnt[i] = s.cnt[i] - 16'h0001;
                            n.psc[i] = s.pre[i];
                        end
                    end
                end
            end
            default: begin
                n.reload = 2'b00;
            end
        endcase

        if (reg_wr) begin
            case (reg_addr)
                `GPT_OFS_CFG: begin
                    // configuration value picks joined or split
                    n.cfg = reg_wdata[2:0];
                end

                `GPT_OFS_MODE_A: begin
                    // in the joined down-counter half a alone picks the kind; the seconds counter reads neither mode
                    n.mode[0] = reg_wdata[1:0];
                end

                `GPT_OFS_MODE_B: begin
                    n.mode[1] = reg_wdata[1:0];
                end

                `GPT_OFS_CTL: begin
                    // only the defined bits are kept; the rest read back zero
                    n.ctl = 16'h0000;
                    n.ctl[`GPT_CTL_EN] = reg_wdata[`GPT_CTL_EN];
                    n.ctl[`GPT_CTL_STALL] = reg_wdata[`GPT_CTL_STALL];
                    n.ctl[`GPT_CTL_CAL] = reg_wdata[`GPT_CTL_CAL];
                    n.ctl[`GPT_CTL_OTE] = reg_wdata[`GPT_CTL_OTE];
                    n.ctl[`GPT_CTL_EN + `GPT_HALF_STRIDE] = reg_wdata[`GPT_CTL_EN + `GPT_HALF_STRIDE];
                    n.ctl[`GPT_CTL_STALL + `GPT_HALF_STRIDE] = reg_wdata[`GPT_CTL_STALL + `GPT_HALF_STRIDE];
                    n.ctl[`GPT_CTL_OTE + `GPT_HALF_STRIDE] = reg_wdata[`GPT_CTL_OTE + `GPT_HALF_STRIDE];
                end

                `GPT_OFS_IMR: begin
                    // unused mask bits read back zero
                    n.imr = 16'h0000;
                    n.imr[`GPT_IRQ_TO] = reg_wdata[`GPT_IRQ_TO];
                    n.imr[`GPT_IRQ_MATCH] = reg_wdata[`GPT_IRQ_MATCH];
                    n.imr[`GPT_IRQ_TO + `GPT_HALF_STRIDE] = reg_wdata[`GPT_IRQ_TO + `GPT_HALF_STRIDE];
                end

                `GPT_OFS_ICR: begin
                    // ones clear; a new event in the same cycle still wins
                    clr_v = reg_wdata[15:0];
                end

                `GPT_OFS_ILR_A: begin
                    // joined write splits into both halves
                    n.ild[0] = reg_wdata[15:0];
                    if (joined) begin
                        n.ild[1] = reg_wdata[31:16];
                    end
                    // running counter takes new load next cycle, except in seconds mode
                    n.reload[0] = (s.cfg != `GPT_CFG_CLOCK);
                end

                `GPT_OFS_ILR_B: begin
                    // half b load re-arms only when the halves are split
                    n.ild[1] = reg_wdata[15:0];
                    n.reload[1] = (s.cfg == `GPT_CFG_SPLIT);
                end

                `GPT_OFS_MATCH_A: begin
                    n.mt[0] = reg_wdata[15:0];
                    if (joined) begin
                        n.mt[1] = reg_wdata[31:16];
                    end
                end

                `GPT_OFS_MATCH_B: begin
                    n.mt[1] = reg_wdata[15:0];
                end

                `GPT_OFS_PRE_A: begin
                    // takes effect at the next count step or reload
                    n.pre[0] = reg_wdata[7:0];
                end

                `GPT_OFS_PRE_B: begin
                    n.pre[1] = reg_wdata[7:0];
                end

                `GPT_OFS_RIS, `GPT_OFS_MIS, `GPT_OFS_CNT_A, `GPT_OFS_CNT_B: begin
                    // status and counts are read only; writes are dropped
                end

                default: begin
                end
            endcase
        end

        // a new event beats a clear in the same cycle
        n.ris = (s.ris & ~clr_v) | set_v;
        n.irq = |(n.ris & n.imr);

        n.rdata = 32'h00000000;
        if (reg_rd) begin
            case (reg_addr)
                `GPT_OFS_CFG: begin
                    n.rdata = {29'h0, s.cfg};
                end

                `GPT_OFS_MODE_A: begin
                    n.rdata = {30'h0, s.mode[0]};
                end

                `GPT_OFS_MODE_B: begin
                    n.rdata = {30'h0, s.mode[1]};
                end

                `GPT_OFS_CTL: begin
                    n.rdata = {16'h0, s.ctl};
                end

                `GPT_OFS_IMR: begin
                    n.rdata = {16'h0, s.imr};
                end

                `GPT_OFS_RIS: begin
                    n.rdata = {16'h0, s.ris};
                end

                `GPT_OFS_MIS: begin
                    n.rdata = {16'h0, s.ris & s.imr};
                end

                `GPT_OFS_ILR_A: begin
                    // joined load reads back both halves
                    if (joined) begin
                        n.rdata = s.ild;
                    end else begin
                        n.rdata = {16'h0, s.ild[0]};
                    end
                end

                `GPT_OFS_ILR_B: begin
                    n.rdata = {16'h0, s.ild[1]};
                end

                `GPT_OFS_MATCH_A: begin
                    if (joined) begin
                        n.rdata = s.mt;
                    end else begin
                        n.rdata = {16'h0, s.mt[0]};
                    end
                end

                `GPT_OFS_MATCH_B: begin
                    n.rdata = {16'h0, s.mt[1]};
                end

                `GPT_OFS_PRE_A: begin
                    n.rdata = {24'h0, s.pre[0]};
                end

                `GPT_OFS_PRE_B: begin
                    n.rdata = {24'h0, s.pre[1]};
                end

                `GPT_OFS_CNT_A: begin
                    if (joined) begin
                        n.rdata = s.cnt;
                    end else begin
                        n.rdata = {16'h0, s.cnt[0]};
                    end
                end

                `GPT_OFS_CNT_B: begin
                    n.rdata = {16'h0, s.cnt[1]};
                end

                default: begin
                    n.rdata = 32'h00000000;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            // idle with counters and loads all ones
            s.cfg <= `GPT_CFG_JOINED;
            s.mode <= 4'h0;
            s.ctl <= 16'h0000;
            s.imr <= 16'h0000;
            s.ris <= 16'h0000;
            s.ild <= {`GPT_CNT_RST, `GPT_CNT_RST};
            s.mt <= 32'h00000000;
            s.cnt <= {`GPT_CNT_RST, `GPT_CNT_RST};
            s.pre <= {`GPT_PRE_RST, `GPT_PRE_RST};
            s.psc <= {`GPT_PRE_RST, `GPT_PRE_RST};
            // nothing pending, so no pulse or reload right after release
            s.reload <= 2'h0;
            s.trig <= 2'h0;
            s.clock_seen <= 1'b0;
            // level starts low like an idle reference: no false edge after reset
            s.sync <= 3'h0;
            s.ref_lvl <= 1'b0;
            s.div <= 16'h0000;
            s.irq <= 1'b0;
            s.rdata <= 32'h00000000;
        end else begin
            s <= n;
        end
    end

    assign reg_rdata = s.rdata;
    assign irq = s.irq;
    assign trig_a = s.trig[0];
    assign trig_b = s.trig[1];
endmodule
`default_nettype wire

// *** verification/gpt_ref_source.sv ***
// reference clock source for the seconds counter
`timescale 1ns/1ps
`default_nettype none
module gpt_ref_source #(
    parameter realtime HALF_NS = 15258.789
) (
    input wire logic run,
    output logic ref_clk
);
    initial begin
        ref_clk = 1'b0;
    end
    // 32.768 kHz reference
    // finishes the half period under way when run falls, then stands still, so at most one stray edge reaches the divider
    always begin
        wait (run);
        #(HALF_NS) ref_clk = ~ref_clk;
    end
endmodule
`default_nettype wire

// *** verification/gpt_timer_pair_properties.sv ***
// port checker of the timer pair
`timescale 1ns/1ps
`default_nettype none
`include "gpt_map.svh"
module gpt_timer_pair_properties #(
    parameter int REF_PER_TICK = 4
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic halt,
    input wire logic capture_pin_0,
    input wire logic irq,
    input wire logic trig_a,
    input wire logic trig_b
);
    logic [15:0] ctl_r;
    logic [2:0] cfg_r;
    logic [15:0] imr_r;
    // write shadows; only the enable bits are cleared by hardware, never used here
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ctl_r <= 16'h0000;
            cfg_r <= 3'h0;
            imr_r <= 16'h0000;
        end else if (reg_wr) begin
            if (reg_addr == `GPT_OFS_CTL) ctl_r <= reg_wdata[15:0];
            if (reg_addr == `GPT_OFS_CFG) cfg_r <= reg_wdata[2:0];
            if (reg_addr == `GPT_OFS_IMR) imr_r <= reg_wdata[15:0];
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);
    property p_reset_quiet;
        $rose(resetn) |-> !irq && !trig_a && !trig_b;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("output active at reset release");
    property p_trig_a_pulse;
        trig_a |=> !trig_a;
    endproperty
    a_trig_a_pulse: assert property (p_trig_a_pulse) else $error("trigger a longer than one cycle");
    property p_trig_b_pulse;
        trig_b |=> !trig_b;
    endproperty
    a_trig_b_pulse: assert property (p_trig_b_pulse) else $error("trigger b longer than one cycle");
    property p_trig_a_gate;
        !ctl_r[5] |=> !trig_a;
    endproperty
    a_trig_a_gate: assert property (p_trig_a_gate) else $error("trigger a while disabled");
    property p_trig_b_split;
        (cfg_r != `GPT_CFG_SPLIT || !ctl_r[13]) |=> !trig_b;
    endproperty
    a_trig_b_split: assert property (p_trig_b_split) else $error("trigger b outside split mode");
    property p_stall_a;
        halt && ctl_r[1] && !ctl_r[4] |=> !trig_a;
    endproperty
    a_stall_a: assert property (p_stall_a) else $error("half a ran while stalled");
    property p_stall_b;
        halt && ctl_r[9] && !ctl_r[4] |=> !trig_b;
    endproperty
    a_stall_b: assert property (p_stall_b) else $error("half b ran while stalled");
    property p_irq_mask;
        imr_r == 16'h0000 |=> !irq;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("interrupt with all masked");
    property p_irq_timeout;
        trig_a && imr_r[0] |=> irq;
    endproperty
    a_irq_timeout: assert property (p_irq_timeout) else $error("no interrupt after time-out");
endmodule
bind gpt_timer_pair gpt_timer_pair_properties #(.REF_PER_TICK(REF_PER_TICK)) u_props (.clock(clock),
    .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .halt(halt), .capture_pin_0(capture_pin_0), .irq(irq), .trig_a(trig_a),
    .trig_b(trig_b));
`default_nettype wire

// *** verification/gpt_timer_pair_bench.sv ***
// register-level bench of the timer pair
`timescale 1ns/1ps
`default_nettype none
`include "gpt_map.svh"
module gpt_timer_pair_bench;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic halt = 1'b0;
    logic ref_run = 1'b0;
    logic ref_clk;
    logic [31:0] reg_rdata;
    logic irq;
    logic trig_a;
    logic trig_b;
    int fail_count = 0;
    int n_compared = 0;
    int n;
    gpt_timer_pair #(.REF_PER_TICK(4)) dut (.clock(clock), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .halt(halt),
        .capture_pin_0(ref_clk), .irq(irq), .trig_a(trig_a), .trig_b(trig_b));
    gpt_ref_source u_ref (.run(ref_run), .ref_clk(ref_clk));
    initial begin
        forever #2 clock = ~clock;
    end
    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        chk(what, exp, reg_rdata);
    endtask
    function automatic logic sel(input int w);
        return w == 0 ? trig_a : (w == 1 ? trig_b : irq);
    endfunction
    // cycles up to the next event; a missing event ends the run
    task automatic wait_for(input int w, input int lim, output int cyc);
        cyc = 0;
        do begin
            @(posedge clock);
            #1;
            cyc++;
        end while (sel(w) !== 1'b1 && cyc < lim);
        if (sel(w) !== 1'b1) begin
            fail_count++;
            $display("[FAIL] event %0d expected 1 seen 0", w);
            summarize();
        end
    endtask
    task automatic count_hi(input int w, input int cyc, output int k);
        k = 0;
        repeat (cyc) begin
            @(posedge clock);
            #1;
            k += int'(sel(w) === 1'b1);
        end
    endtask
    initial begin
        repeat (6) @(posedge clock);
        resetn <= 1'b1;
        rd(`GPT_OFS_ILR_A, 32'hffffffff, "load");
        rd(`GPT_OFS_CNT_A, 32'hffffffff, "count");
        rd(`GPT_OFS_PRE_A, 32'h0, "prescale a");
        rd(`GPT_OFS_PRE_B, 32'h0, "prescale b");
        rd(`GPT_OFS_CTL, 32'h0, "control");
        rd(8'h10, 32'h0, "unmapped");
        $display("test reset done");
        wr(`GPT_OFS_MODE_A, 32'h2);
        wr(`GPT_OFS_ILR_A, 32'h00030004);
        rd(`GPT_OFS_ILR_B, 32'h3, "load upper");
        rd(`GPT_OFS_CNT_A, 32'h00030004, "count pair");
        wr(`GPT_OFS_ILR_A, 32'h6);
        wr(`GPT_OFS_IMR, 32'h1);
        wr(`GPT_OFS_CTL, 32'h21);
        wait_for(0, 100, n);
        wait_for(0, 100, n);
        chk("period", 32'd8, n);
        wr(`GPT_OFS_ILR_A, 32'h2);
        wait_for(0, 100, n);
        wait_for(0, 100, n);
        chk("new period", 32'd4, n);
        rd(`GPT_OFS_RIS, 32'h1, "raw");
        rd(`GPT_OFS_MIS, 32'h1, "masked");
        chk("irq", 32'h1, {31'h0, irq});
        wr(`GPT_OFS_CTL, 32'h0);
        wr(`GPT_OFS_ICR, 32'h1);
        rd(`GPT_OFS_RIS, 32'h0, "raw cleared");
        $display("test joined done");
        wr(`GPT_OFS_MODE_A, 32'h1);
        wr(`GPT_OFS_ILR_A, 32'h3);
        wr(`GPT_OFS_CTL, 32'h21);
        wait_for(0, 100, n);
        rd(`GPT_OFS_CTL, 32'h20, "enable cleared");
        count_hi(0, 20, n);
        chk("one-shot extra", 32'd0, n);
        wr(`GPT_OFS_MODE_A, 32'h2);
        @(posedge clock);
        halt <= 1'b1;
        wr(`GPT_OFS_CTL, 32'h23);
        count_hi(0, 40, n);
        chk("stalled pulses", 32'd0, n);
        @(posedge clock);
        halt <= 1'b0;
        wait_for(0, 20, n);
        wr(`GPT_OFS_CTL, 32'h0);
        wr(`GPT_OFS_ICR, 32'h109);
        $display("test one-shot and stall done");
        wr(`GPT_OFS_CFG, 32'h4);
        wr(`GPT_OFS_MODE_B, 32'h2);
        wr(`GPT_OFS_ILR_B, 32'h3);
        wr(`GPT_OFS_PRE_B, 32'h1);
        wr(`GPT_OFS_IMR, 32'h100);
        wr(`GPT_OFS_CTL, 32'h2100);
        wait_for(1, 100, n);
        wait_for(1, 100, n);
        chk("split period", 32'd9, n);
        rd(`GPT_OFS_MIS, 32'h100, "masked b");
        wr(`GPT_OFS_CTL, 32'h0);
        wr(`GPT_OFS_ICR, 32'h109);
        $display("test split done");
        wr(`GPT_OFS_CFG, 32'h1);
        rd(`GPT_OFS_CNT_A, 32'h1, "clock start");
        wr(`GPT_OFS_MATCH_A, 32'h1);
        wr(`GPT_OFS_IMR, 32'h8);
        wr(`GPT_OFS_CTL, 32'h1);
        ref_run <= 1'b1;
        wait_for(2, 40000, n);
        ref_run <= 1'b0;
        // four reference periods, less one half period
        chk("tick time", 32'h1, {31'h0, n > 26000 && n < 27000});
        rd(`GPT_OFS_CNT_A, 32'h0, "roll over");
        rd(`GPT_OFS_RIS, 32'h8, "match raw");
        rd(`GPT_OFS_MIS, 32'h8, "match masked");
        wr(`GPT_OFS_ICR, 32'h8);
        rd(`GPT_OFS_MIS, 32'h0, "match cleared");
        $display("test clock mode done");
        summarize();
    end
endmodule
`default_nettype wire
